// ### hw/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  logic link_clk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic rst_n;
  logic rdy_out;
  logic rdy_oe_n;
  logic rdy_n;
  // Open-drain ready line, pulled up when released
  assign rdy_n = rdy_oe_n ? 1'b1 : rdy_out;
  modport dev (
    input link_clk,
    input sel_n,
    input mosi,
    input rst_n,
    output miso,
    output rdy_out,
    output rdy_oe_n
  );
  modport host (
    output link_clk,
    output sel_n,
    output mosi,
    output rst_n,
    input miso,
    input rdy_n
  );
endinterface

// ### hw/adc_seq_device.sv
`timescale 1ns/1ps
// Summary of operation
// - Counter byte leads result when enabled
// - Counter zero at reset, increments, wraps
// - Reset or enable toggle zeroes counter
// - Integrity covers registers, results and counter
// - Mode 01 appends inverted data copy
// - Mode 10 appends 16-bit checksum
// - CRC-16-CCITT, preset all ones
// - Host rechecks checksum, rereads on mismatch
// - Any reset restores defaults, idles
// - Power-on reset held about 500 us
// - Host honours reset pulse and wait
// - Commands 06h/07h reset, no wait
// - Host triggers after mode bit change
// - Single-shot: one conversion, then low power
// - Single-shot config write restarts conversion
// - Continuous: store result, start next
// - Continuous start delay 28.5/105 clocks; normal delay rounded up to 29 clocks
// - Continuous config write restarts conversion
// - Power-down finishes conversion, stops converting
// - Trigger wakes from power-down
// - Normal mode modulator at quarter clock
// - Turbo mode doubles modulator rate
// - Ready low on result, high on read
module adc_seq_device
  import adc_seq_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES,
  parameter int CONV_TICKS = CONV_TICKS_MAX
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  adc_link_if.dev link,
  input wire logic [15:0] sample_i,
  output logic analog_en_o,
  output logic excitation_en_o,
  output logic mod_tick_o,
  output logic low_power_o
);
  localparam int PW = $clog2(POR_CYC + 1);
  localparam int TW = $clog2(CONV_TICKS + 1);
  localparam int DW = $clog2(START_TURBO_CYC + 1);
  localparam logic [1:0] DIV_N = 2'(MOD_DIV_NORMAL - 1);
  localparam logic [1:0] DIV_T = 2'(MOD_DIV_TURBO - 1);

  if (CONV_TICKS < 2 * TOP_RATE_DIV || POR_CYC < 1) begin : g_chk
    $error("conversion or power-on count too small");
  end

  logic [3:0] raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic clk_d_q;
  logic [PW-1:0] por_q;
  logic soft_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic wr_pend_q;
  logic [1:0] wr_idx_q;
  logic [47:0] tx_q;
  logic miso_q;
  logic [7:0] cfg_q [NUM_CFG];
  dev_state_t st_q;
  dev_state_t st_d;
  logic cont_q;
  logic pd_q;
  logic [1:0] div_q;
  logic [TW-1:0] tk_q;
  logic [DW-1:0] dly_q;
  logic [15:0] res_q;
  logic [7:0] cnt_q;
  logic rdy_oe_n_q;

  assign raw = {link.link_clk, link.sel_n, link.mosi, link.rst_n};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        s1_q[g] <= SYNC_INIT[g];
        s2_q[g] <= SYNC_INIT[g];
      end else begin
        s1_q[g] <= raw[g];
        s2_q[g] <= s1_q[g];
      end
    end
  end

  wire clk_s = s2_q[3];
  wire frame = !s2_q[2];
  wire mosi_s = s2_q[1];
  wire pin_s = s2_q[0];
  wire rise = clk_s & !clk_d_q;
  wire fall = !clk_s & clk_d_q;

  // hold internal reset after supply good
  wire por_busy = por_q != PW'(POR_CYC);
  wire hard_rst = !resetn_i | por_busy | !pin_s;
  // every reset source reaches the core
  wire core_rst = hard_rst | soft_q;

  wire byte_v = frame & rise & (bit_q == 3'd7);
  wire [7:0] rx_byte = {sh_q[6:0], mosi_s};
  wire cmd_v = byte_v & !wr_pend_q;
  wire is_rst = cmd_v & (rx_byte == CMD_RESET_A | rx_byte == CMD_RESET_B);
  wire is_trig = cmd_v & (rx_byte == CMD_TRIG);
  wire is_pd = cmd_v & (rx_byte == CMD_PDOWN);
  wire is_rdata = cmd_v & (rx_byte == CMD_RDATA);
  wire is_rreg = cmd_v & (rx_byte[7:4] == CMD_RREG_HI);
  wire is_wreg = cmd_v & (rx_byte[7:4] == CMD_WREG_HI);
  wire cfg_we = byte_v & wr_pend_q;

  wire cm = cfg_q[MODE_REG][CM_BIT];
  wire turbo = cfg_q[MODE_REG][TURBO_BIT];
  wire [2:0] rate = cfg_q[MODE_REG][RATE_LSB +: 3];
  wire [1:0] integ = cfg_q[INTEG_REG][INTEG_LSB +: 2];
  wire cnt_en = cfg_q[INTEG_REG][CNT_EN_BIT];

  function automatic logic [TW-1:0] rate_ticks(input logic [2:0] r);
    case (r)
      3'd0: return TW'(CONV_TICKS);
      3'd1: return TW'(CONV_TICKS / 2);
      3'd2: return TW'(CONV_TICKS / 4);
      3'd3: return TW'(CONV_TICKS / 8);
      3'd4: return TW'(CONV_TICKS / 16);
      3'd5: return TW'(CONV_TICKS / 32);
      default: return TW'(CONV_TICKS / TOP_RATE_DIV);
    endcase
  endfunction

  // Payload bytes left-aligned, then copy or checksum
  function automatic logic [47:0] make_frame(input logic [23:0] pay, input logic [1:0] n,
                                             input logic [1:0] mode);
    logic [47:0] f;
    logic [15:0] crc;
    int nn;
    f = '1;
    crc = CRC_PRESET;
    nn = int'(n);
    for (int i = 0; i < 3; i++) begin
      if (i < nn) begin
        f[47 - 8 * i -: 8] = pay[23 - 8 * i -: 8];
        crc = crc16_byte(crc, pay[23 - 8 * i -: 8]);
        if (mode == INTEG_INV) begin
          f[47 - 8 * (nn + i) -: 8] = ~pay[23 - 8 * i -: 8];
        end
      end
    end
    if (mode == INTEG_CRC) begin
      f[47 - 8 * nn -: 16] = crc;
    end
    return f;
  endfunction

  wire [23:0] pay_w = is_rreg ? {cfg_q[rx_byte[1:0]], 16'h0000} :
                      cnt_en ? {cnt_q, res_q} : {res_q, 8'h00};
  wire [1:0] pay_n = is_rreg ? 2'd1 : (cnt_en ? 2'd3 : 2'd2);
  // same framing for registers and results
  wire [47:0] frame_w = make_frame(pay_w, pay_n, integ);
  wire load = is_rdata | is_rreg;

  // quarter-rate modulator tick; doubled in turbo
  wire tick = div_q == (turbo ? DIV_T : DIV_N);
  wire [TW-1:0] conv_len = rate_ticks(rate);
  wire done = (st_q == ST_CONV) & tick & (tk_q == conv_len - 1'b1);
  wire [DW-1:0] dly_len = turbo ? DW'(START_TURBO_CYC) : DW'(START_NORM_CYC);
  wire dly_end = (st_q == ST_DELAY) & (dly_q == dly_len - 1'b1);
  // config write or trigger restarts conversion
  wire tk_clr = (st_q != ST_CONV) | done | cfg_we | is_trig;
  wire dly_clr = (st_q != ST_DELAY) | is_trig;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE, ST_PDOWN: begin
        // trigger wakes; mode bit picks kind
        if (is_trig) begin
          st_d = cm ? ST_DELAY : ST_CONV;
        end else if (is_pd) begin
          st_d = ST_PDOWN;
        end
      end
      ST_DELAY: begin
        if (is_pd) begin
          st_d = ST_PDOWN;
        end else if (dly_end & !is_trig) begin
          st_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (done & (pd_q | is_pd)) begin
          st_d = ST_PDOWN;
        end else if (done & cont_q) begin
          st_d = ST_CONV;
        end else if (done) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      por_q <= '0;
    end else if (por_busy) begin
      por_q <= por_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      soft_q <= 1'b0;
      clk_d_q <= 1'b0;
    end else begin
      soft_q <= is_rst;
      clk_d_q <= clk_s;
    end
  end

  // Link stays up across a command reset so the frame ends cleanly
  always_ff @(posedge ref_clk_i) begin
    if (hard_rst | !frame) begin
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 2'd0;
    end else if (rise) begin
      sh_q <= rx_byte;
      bit_q <= bit_q + 1'b1;
      if (byte_v) begin
        wr_pend_q <= is_wreg;
        wr_idx_q <= rx_byte[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst | !frame) begin
      tx_q <= '1;
      miso_q <= 1'b1;
    end else if (load) begin
      tx_q <= frame_w;
    end else if (fall) begin
      miso_q <= tx_q[47];
      tx_q <= {tx_q[46:0], 1'b1};
    end
  end

  for (genvar r = 0; r < NUM_CFG; r++) begin : g_cfg
    always_ff @(posedge ref_clk_i) begin
      if (core_rst) begin
        cfg_q[r] <= CFG_RESET;
      end else if (cfg_we & (wr_idx_q == 2'(r))) begin
        cfg_q[r] <= rx_byte;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      st_q <= ST_IDLE;
      cont_q <= 1'b0;
      pd_q <= 1'b0;
      div_q <= 2'd0;
    end else begin
      st_q <= st_d;
      cont_q <= is_trig ? cm : cont_q;
      pd_q <= (st_q == ST_CONV) & !done & (pd_q | is_pd);
      div_q <= tick ? 2'd0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst | tk_clr) begin
      tk_q <= '0;
    end else if (tick) begin
      tk_q <= tk_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst | dly_clr) begin
      dly_q <= '0;
    end else begin
      dly_q <= dly_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      res_q <= 16'h0000;
    end else if (done) begin
      res_q <= sample_i;
    end
  end

  // zero while disabled or in reset, wraps naturally
  always_ff @(posedge ref_clk_i) begin
    if (core_rst | !cnt_en) begin
      cnt_q <= 8'h00;
    end else if (done) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // new result wins over a same-cycle read
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      rdy_oe_n_q <= 1'b1;
    end else begin
      rdy_oe_n_q <= !(done | (!rdy_oe_n_q & !is_rdata));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      analog_en_o <= 1'b0;
      excitation_en_o <= 1'b0;
      mod_tick_o <= 1'b0;
      low_power_o <= 1'b1;
    end else begin
      analog_en_o <= (st_d == ST_CONV) | (st_d == ST_DELAY);
      excitation_en_o <= st_d != ST_PDOWN;
      mod_tick_o <= tick & (st_q == ST_CONV);
      low_power_o <= (st_d == ST_IDLE) | (st_d == ST_PDOWN);
    end
  end

  assign link.miso = miso_q;
  assign link.rdy_oe_n = rdy_oe_n_q;
  assign link.rdy_out = 1'b0;
endmodule

// ### hw/adc_seq_host.sv
`timescale 1ns/1ps
module adc_seq_host
  import adc_seq_pkg::*;
#(
  parameter int LINK_HALF = LINK_HALF_DEF,
  parameter int MAX_RETRY = MAX_RETRY_DEF
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  adc_link_if.host link,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  localparam int HW = $clog2(LINK_HALF + 1);
  localparam int RW = $clog2(RST_LOW_CYC + RST_WAIT_CYC + 1);

  // Device needs two sync stages plus edge detect per half period
  if (LINK_HALF < 6 || MAX_RETRY > 7) begin : g_chk
    $error("link half period or retry count out of range");
  end

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  host_state_t st_q;
  logic [HW-1:0] ph_q;
  logic [RW-1:0] rc_q;
  logic [5:0] bit_q;
  logic [5:0] last_q;
  logic [2:0] nrx_q;
  logic [15:0] tx_q;
  logic [47:0] rx_q;
  logic [7:0] rxb_q [RX_BYTES];
  logic [7:0] cmd_q;
  logic [7:0] wdata_q;
  logic [3:0] hcfg_q;
  logic [2:0] tries_q;
  logic pend_q;
  logic crc_err_q;
  logic fail_q;
  logic clk_q;
  logic sel_n_q;
  logic mosi_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s1_q <= 2'b11;
      s2_q <= 2'b11;
    end else begin
      s1_q <= {link.miso, link.rdy_n};
      s2_q <= s1_q;
    end
  end

  function automatic logic is_read(input logic [7:0] c);
    return (c == CMD_RDATA) | (c[7:4] == CMD_RREG_HI);
  endfunction

  function automatic logic [1:0] pay_len(input logic [7:0] c, input logic [3:0] h);
    return (c[7:4] == CMD_RREG_HI) ? 2'd1 : h[1:0];
  endfunction

  wire miso_s = s2_q[1];
  wire rdy_s = !s2_q[0];
  wire [1:0] mode = hcfg_q[3:2];
  wire idle = st_q == HS_IDLE;
  wire ph_end = ph_q == HW'(LINK_HALF - 1);
  wire cmd_wr = we_i & (addr_i == H_CMD) & idle & !pend_q;
  wire rst_go = we_i & (addr_i == H_CTRL) & wdata_i[0] & idle & !pend_q;
  // follow-up frames need only the idle gap
  wire go = cmd_wr | (idle & pend_q & ph_end);
  wire [7:0] c_new = pend_q ? cmd_q : wdata_i;
  wire [2:0] p_new = {1'b0, pay_len(c_new, hcfg_q)};
  wire [2:0] resp = (mode == INTEG_INV) ? 3'(2 * p_new) :
                    (mode == INTEG_CRC) ? 3'(p_new + 3'd2) : p_new;
  wire [2:0] nrx = is_read(c_new) ? resp : 3'd0;
  wire [2:0] ntx = (c_new[7:4] == CMD_WREG_HI) ? 3'd2 : 3'd1;
  wire frame_end = (st_q == HS_HIGH) & ph_end & (bit_q == last_q);
  wire [1:0] p_cur = pay_len(cmd_q, hcfg_q);

  // recompute over payload, compare to last word
  function automatic logic crc_bad(input logic [47:0] rx, input logic [1:0] p);
    logic [15:0] c;
    c = CRC_PRESET;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(p)) begin
        c = crc16_byte(c, rx[8 * (int'(p) + 1 - i) +: 8]);
      end
    end
    return c != rx[15:0];
  endfunction

  wire bad = is_read(cmd_q) & (mode == INTEG_CRC) & crc_bad(rx_q, p_cur);
  // mode-register write is followed by a trigger
  wire follow = (cmd_q[7:4] == CMD_WREG_HI) & (cmd_q[1:0] == MODE_REG);
  wire retry = bad & (tries_q < 3'(MAX_RETRY));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_q <= HS_IDLE;
      ph_q <= '0;
      rc_q <= '0;
      bit_q <= 6'd0;
      last_q <= 6'd0;
      nrx_q <= 3'd0;
      tx_q <= 16'h0000;
      rx_q <= '0;
      clk_q <= 1'b0;
      sel_n_q <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      ph_q <= (ph_end | go) ? '0 : ph_q + 1'b1;
      case (st_q)
        HS_IDLE: begin
          rc_q <= '0;
          if (rst_go) begin
            st_q <= HS_RST;
          end else if (go) begin
            st_q <= HS_LOW;
            sel_n_q <= 1'b0;
            // Zeros after a read command, since the device decodes them as commands
            tx_q <= {c_new, (ntx == 3'd2) ? wdata_q : 8'h00};
            mosi_q <= c_new[7];
            bit_q <= 6'd0;
            last_q <= 6'({3'd0, ntx + nrx} * 6'd8 - 6'd1);
            nrx_q <= nrx;
          end
        end
        HS_LOW: begin
          if (ph_end) begin
            clk_q <= 1'b1;
            rx_q <= {rx_q[46:0], miso_s};
            st_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (ph_end) begin
            clk_q <= 1'b0;
            if (frame_end) begin
              sel_n_q <= 1'b1;
              st_q <= HS_IDLE;
            end else begin
              bit_q <= bit_q + 6'd1;
              mosi_q <= tx_q[14];
              tx_q <= {tx_q[14:0], 1'b0};
              st_q <= HS_LOW;
            end
          end
        end
        HS_RST: begin
          // pin low for minimum width, then wait
          rc_q <= rc_q + 1'b1;
          if (rc_q == RW'(RST_LOW_CYC + RST_WAIT_CYC - 1)) begin
            st_q <= HS_IDLE;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rst_n_q <= 1'b1;
    end else begin
      rst_n_q <= !((st_q == HS_RST) & (rc_q < RW'(RST_LOW_CYC - 1)) | rst_go);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cmd_q <= 8'h00;
      pend_q <= 1'b0;
      tries_q <= 3'd0;
      crc_err_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (cmd_wr) begin
      cmd_q <= wdata_i;
      tries_q <= 3'd0;
      crc_err_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (go) begin
      pend_q <= 1'b0;
    end else if (frame_end) begin
      crc_err_q <= crc_err_q | bad;
      fail_q <= bad & !retry;
      tries_q <= retry ? tries_q + 3'd1 : tries_q;
      pend_q <= retry | (follow & !bad);
      cmd_q <= (follow & !bad) ? CMD_TRIG : cmd_q;
    end
  end

  for (genvar k = 0; k < RX_BYTES; k++) begin : g_rx
    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        rxb_q[k] <= 8'h00;
      end else if (frame_end) begin
        rxb_q[k] <= (k < int'(nrx_q)) ? rx_q[8 * (int'(nrx_q) - 1 - k) +: 8] : 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wdata_q <= 8'h00;
      hcfg_q <= 4'h0;
    end else if (we_i & (addr_i == H_WDATA)) begin
      wdata_q <= wdata_i;
    end else if (we_i & (addr_i == H_CFG)) begin
      hcfg_q <= wdata_i[3:0];
    end
  end

  wire in_rx = (addr_i >= H_RX0) & (addr_i < H_RX0 + 4'(RX_BYTES));
  wire [3:0] rx_idx = addr_i - H_RX0;
  wire busy = !idle | pend_q;
  wire [7:0] rd_mux = (addr_i == H_WDATA) ? wdata_q :
                      (addr_i == H_CFG) ? {4'h0, hcfg_q} :
                      (addr_i == H_CTRL) ? {7'h00, st_q == HS_RST} :
                      (addr_i == H_STAT) ? {4'h0, fail_q, crc_err_q, busy, rdy_s} :
                      in_rx ? rxb_q[rx_idx[2:0]] : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= re_i ? rd_mux : 8'h00;
    end
  end

  assign link.link_clk = clk_q;
  assign link.sel_n = sel_n_q;
  assign link.mosi = mosi_q;
  assign link.rst_n = rst_n_q;
endmodule

// ### hw/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int CLK_MHZ = 200;
  localparam int POR_TIME_US = 500;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  // Start delays in system-clock half periods
  localparam int START_NORM_HALVES = 57;
  localparam int START_TURBO_HALVES = 210;
  localparam int START_NORM_CYC = (START_NORM_HALVES + 1) / 2;
  localparam int START_TURBO_CYC = (START_TURBO_HALVES + 1) / 2;
  localparam int MOD_DIV_NORMAL = 4;
  localparam int MOD_DIV_TURBO = 2;
  localparam int MOD_NORMAL_KHZ = 256;
  localparam int MIN_RATE_SPS = 20;
  localparam int CONV_TICKS_MAX = MOD_NORMAL_KHZ * 1000 / MIN_RATE_SPS;
  localparam int TOP_RATE_DIV = 50;
  localparam int LINK_HALF_DEF = 12;
  localparam int RST_LOW_MIN_NS = 200;
  localparam int RST_TRAFFIC_NS = 500;
  localparam int RST_LOW_CYC = (RST_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_WAIT_CYC = (RST_TRAFFIC_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_RETRY_DEF = 3;
  localparam logic [3:0] SYNC_INIT = 4'h5;

  localparam logic [7:0] CMD_PDOWN = 8'h02;
  localparam logic [7:0] CMD_RESET_A = 8'h06;
  localparam logic [7:0] CMD_RESET_B = 8'h07;
  localparam logic [7:0] CMD_TRIG = 8'h08;
  localparam logic [7:0] CMD_RDATA = 8'h10;
  localparam logic [3:0] CMD_RREG_HI = 4'h2;
  localparam logic [3:0] CMD_WREG_HI = 4'h4;

  localparam int NUM_CFG = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [1:0] MODE_REG = 2'd1;
  localparam int CM_BIT = 3;
  localparam int TURBO_BIT = 4;
  localparam int RATE_LSB = 5;
  localparam logic [1:0] INTEG_REG = 2'd2;
  localparam int INTEG_LSB = 4;
  localparam int CNT_EN_BIT = 6;
  localparam logic [1:0] INTEG_INV = 2'b01;
  localparam logic [1:0] INTEG_CRC = 2'b10;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_WDATA = 4'h1;
  localparam logic [3:0] H_CFG = 4'h2;
  localparam logic [3:0] H_CTRL = 4'h3;
  localparam logic [3:0] H_STAT = 4'h4;
  localparam logic [3:0] H_RX0 = 4'h5;
  localparam int RX_BYTES = 6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV = 2'b10,
    ST_PDOWN = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_HIGH = 2'b10,
    HS_RST = 2'b11
  } host_state_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      if (r[15] ^ d[b]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction
endpackage

// ### verification/adc_conversion_sequencer_assertions.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_assertions (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic miso,
  input wire logic rdy_oe_n,
  input wire logic analog_en_o,
  input wire logic excitation_en_o,
  input wire logic mod_tick_o,
  input wire logic low_power_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_quiet;
    rdy_oe_n && low_power_o && !analog_en_o && miso;
  endsequence
  sequence s_por;
    s_quiet [*8];
  endsequence
  a_por_hold: assert property ($rose(resetn_i) |-> s_por)
    else $error("device active too soon after reset release");
  a_reset_idle: assert property (disable iff (1'b0) !resetn_i |=> s_quiet)
    else $error("device not idle under reset");
  a_tick_conv: assert property (mod_tick_o |-> $past(analog_en_o && !low_power_o))
    else $error("modulator tick outside conversion");
  a_tick_gap: assert property (mod_tick_o |=> !mod_tick_o)
    else $error("modulator ticks too close");
  a_excite_on: assert property (analog_en_o |-> excitation_en_o)
    else $error("excitation off while converting");
  a_pdown_low: assert property (!excitation_en_o |-> low_power_o)
    else $error("power-down without low power");
  a_lp_quiet: assert property (low_power_o [*2] |-> !analog_en_o && !mod_tick_o)
    else $error("analog active in low power");
  a_ready_cause: assert property ($fell(rdy_oe_n) |->
    $past(analog_en_o) || $past(analog_en_o, 2))
    else $error("ready asserted without a conversion");
endmodule

// ### verification/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module adc_conversion_sequencer_tb_top;
  import adc_seq_pkg::*;
  typedef struct {logic [7:0] v; logic [7:0] m;} note_t;
  logic ref_clk_i = 0, resetn_i = 0, we_i = 0, re_i = 0, re_d = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, v;
  logic [15:0] sample_i = 16'h0000;
  logic analog_en_o, excitation_en_o, mod_tick_o, low_power_o;
  int miscompares = 0, tests_run = 0;
  note_t notes[$];
  note_t n;
  adc_link_if lnk ();
  adc_seq_device #(.POR_CYC(20), .CONV_TICKS(200)) adc_seq_device_inst (.ref_clk_i, .resetn_i,
    .link(lnk.dev), .sample_i, .analog_en_o, .excitation_en_o, .mod_tick_o, .low_power_o);
  adc_seq_host adc_seq_host_inst (.ref_clk_i, .resetn_i, .link(lnk.host), .addr_i, .wdata_i,
    .we_i, .re_i, .rdata_o);
  adc_conversion_sequencer_assertions adc_conversion_sequencer_assertions_inst (.ref_clk_i,
    .resetn_i, .miso(lnk.miso), .rdy_oe_n(lnk.rdy_oe_n), .analog_en_o, .excitation_en_o,
    .mod_tick_o, .low_power_o);
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (re_d) begin
      n = notes.pop_front();
      if (n.m != 8'h00) `CHK(rdata_o & n.m, n.v & n.m)
    end
    re_d <= re_i;
  end
  task automatic stop_test;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge ref_clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    notes.push_back('{e, m});
    @(posedge ref_clk_i);
    re_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Bounded poll of one status bit
  task automatic idle(input logic [3:0] a, input int b, input logic x);
    int k;
    for (k = 0; k < 3000; k++) begin
      rd(a, 8'h00, 8'h00);
      if (v[b] === x) break;
    end
    if (k == 3000) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(H_CMD, c);
    idle(H_STAT, 1, 1'b0);
  endtask
  task automatic wreg(input logic [1:0] r, input logic [7:0] d);
    wr(H_WDATA, d);
    cmd({CMD_WREG_HI, 2'b00, r});
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic chk_resp(input logic [7:0] b[$], input logic [1:0] im);
    logic [15:0] c;
    int k;
    c = CRC_PRESET;
    k = b.size();
    for (int i = 0; i < k; i++) begin
      if (im == INTEG_INV) b.push_back(~b[i]);
      c = crc(c, b[i]);
    end
    if (im == INTEG_CRC) b.push_back(c[15:8]);
    if (im == INTEG_CRC) b.push_back(c[7:0]);
    foreach (b[i]) rd(H_RX0 + 4'(i), b[i], 8'hff);
  endtask
  task automatic rdata(input logic [7:0] cnt, input logic [1:0] im);
    logic [7:0] b[$];
    b = {cnt, sample_i[15:8], sample_i[7:0]};
    wr(H_CFG, {4'h0, im, 2'd3});
    cmd(CMD_RDATA);
    chk_resp(b, im);
  endtask
  task automatic rreg(input logic [1:0] r, input logic [7:0] e, input logic [1:0] im);
    wr(H_CFG, {4'h0, im, 2'd1});
    cmd({CMD_RREG_HI, 2'b00, r});
    chk_resp('{e}, im);
  endtask
  task automatic trig;
    sample_i <= 16'($urandom);
    cmd(CMD_TRIG);
  endtask
  // Modulator ticks seen in 40 clocks
  task automatic ticks(input int e);
    int t;
    t = 0;
    repeat (40) @(posedge ref_clk_i) t += int'(mod_tick_o);
    `CHK(t, e)
  endtask
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h9d2f));
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (30) @(posedge ref_clk_i);
    // one shot, counter one, ready released by read
    wreg(INTEG_REG, 8'h60);
    trig();
    idle(H_STAT, 0, 1'b1);
    rdata(8'h01, INTEG_CRC);
    rd(H_STAT, 8'h00, 8'h01);
    // write mid-conversion restarts, still one conversion
    trig();
    repeat (200) @(posedge ref_clk_i);
    wreg(2'd0, 8'h5a);
    idle(H_STAT, 0, 1'b1);
    rdata(8'h02, INTEG_CRC);
    wreg(INTEG_REG, 8'h10);
    wreg(INTEG_REG, 8'h50);
    rreg(2'd0, 8'h5a, INTEG_INV);
    trig();
    idle(H_STAT, 0, 1'b1);
    rdata(8'h01, INTEG_INV);
    // two reset codes and the pin
    for (int i = 0; i < 3; i++) begin
      wreg(INTEG_REG, 8'h60);
      if (i < 2) cmd(i ? CMD_RESET_B : CMD_RESET_A);
      else wr(H_CTRL, 8'h01); // pin pulse
      idle(H_CTRL, 0, 1'b0);
      rreg(INTEG_REG, CFG_RESET, 2'b00);
    end
    wreg(MODE_REG, 8'hc8); // host adds the trigger
    idle(H_STAT, 1, 1'b0);
    repeat (300) @(posedge ref_clk_i);
    `CHK(analog_en_o, 1'b1)
    ticks(10);
    cmd(CMD_PDOWN);
    repeat (200) @(posedge ref_clk_i);
    `CHK(low_power_o, 1'b1)
    `CHK(analog_en_o, 1'b0)
    `CHK(excitation_en_o, 1'b0)
    trig();
    repeat (300) @(posedge ref_clk_i);
    `CHK(analog_en_o, 1'b1)
    wreg(MODE_REG, 8'hd8);
    repeat (300) @(posedge ref_clk_i);
    ticks(20);
    stop_test();
  end
endmodule
